// ---- pxr_ext_regs.sv ----
// extended management register bank of the transceiver
// What this block does
// - event field follows event, clears itself
// - writable action bit clears when action done
// - counter ignores writes, clears on read
// - permanent field always reads its default
// - low latch holds zero until read
// - high latch holds one until read
`timescale 1ns/1ps
`include "pxr_regs.svh"
module pxr_ext_regs
  import pxr_pkg::*;
#(
  parameter logic [15:0] P_NP_TX_RESET = 16'h0000
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_clk_en,
  input  wire logic [`PXR_ADDR_W-1:0] i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [`PXR_DATA_W-1:0] i_reg_wdata,
  output logic      [`PXR_DATA_W-1:0] o_rd_data,
  output logic                        o_rd_valid,
  input  wire logic                   i_link_up,
  input  wire logic                   i_jabber,
  input  wire logic                   i_page_rx,
  input  wire logic                   i_false_carrier_evt,
  input  wire logic                   i_rx_err_evt,
  input  wire logic                   i_polarity,
  input  wire logic                   i_sig_detect,
  input  wire logic                   i_descr_lock,
  input  wire logic                   i_remote_fault,
  input  wire logic                   i_an_done,
  input  wire logic                   i_loopback,
  input  wire logic                   i_duplex,
  input  wire logic                   i_speed10,
  input  wire logic                   i_pause_sts,
  input  wire logic                   i_bist_done,
  input  wire logic                   i_bist_pass,
  input  wire logic                   i_polarity_10,
  input  wire logic [4:0]             i_strap_phy_addr,
  output logic      [`PXR_DATA_W-1:0] o_next_page_tx,
  output logic      [`PXR_DATA_W-1:0] o_coding_cfg,
  output logic      [`PXR_DATA_W-1:0] o_phy_ctrl,
  output logic      [4:0]             o_phy_addr,
  output logic                        o_bist_start,
  output logic      [`PXR_DATA_W-1:0] o_ten_cfg,
  output logic      [`PXR_DATA_W-1:0] o_cd_cfg
);
  localparam logic [`PXR_LAT_N-1:0] LAT_HIGH = `PXR_LAT_HIGH_VEC;
  localparam logic [`PXR_CNT_W-1:0] CNT_MAX  = '1;

  // reserved next-page bit must stay zero in the reset image
  if ((P_NP_TX_RESET & ~`PXR_MASK_NEXT_PAGE_TX) != 16'h0000) begin : g_bad_reset
    $error("next page reset value sets a reserved bit");
  end

  pxr_state_t s_q;
  pxr_state_t s_d;

  logic                  rd_ok;
  logic                  wr_ok;
  logic                  rd_status;
  logic [`PXR_LAT_N-1:0] lat_cond;
  logic [`PXR_LAT_N-1:0] lat_val;
  logic [`PXR_DATA_W-1:0] status_word;
  logic [`PXR_DATA_W-1:0] ctrl_word;
  logic [`PXR_DATA_W-1:0] ten_word;

  assign rd_ok     = i_reg_rd & i_clk_en;
  assign wr_ok     = i_reg_wr;
  assign rd_status = i_reg_rd && (i_reg_addr == `PXR_ADDR_STATUS_SUMMARY);
  assign lat_cond  = {i_rx_err_evt, i_false_carrier_evt, i_page_rx, i_jabber, i_link_up};

  for (genvar g = 0; g < `PXR_LAT_N; g++) begin : g_lat
    pxr_latch_bit #(
      .KIND (LAT_HIGH[g] ? PXR_LATCH_HIGH : PXR_LATCH_LOW)
    ) u_lat (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_clk_en   (i_clk_en),
      .i_cond     (lat_cond[g]),
      .i_rd_clear (rd_status),
      .o_val      (lat_val[g])
    );
  end

  // signal detect is live: it rises with the event and drops by itself
  assign status_word = {2'b00,
                        lat_val[`PXR_LAT_RX_ERROR],
                        i_polarity,
                        lat_val[`PXR_LAT_FALSE_CARRIER],
                        i_sig_detect,
                        i_descr_lock,
                        lat_val[`PXR_LAT_PAGE_RX],
                        1'b0,
                        i_remote_fault,
                        lat_val[`PXR_LAT_JABBER],
                        i_an_done,
                        i_loopback,
                        i_duplex,
                        i_speed10,
                        lat_val[`PXR_LAT_LINK]};

  assign ctrl_word = {`PXR_PERM_CTRL_TOP,
                      s_q.phy_ctrl[11],
                      i_bist_pass,
                      s_q.bist_run,
                      s_q.phy_ctrl[8],
                      i_pause_sts,
                      s_q.phy_ctrl[6:0]};

  assign ten_word = {s_q.ten_cfg[15:5], i_polarity_10, s_q.ten_cfg[3:0]};

  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = rd_ok;

    // writes land through a mask so fixed and reserved bits never change
    if (wr_ok) begin
      unique case (i_reg_addr)
        `PXR_ADDR_NEXT_PAGE_TX: begin
          s_d.next_page_tx = i_reg_wdata & `PXR_MASK_NEXT_PAGE_TX;
        end
        `PXR_ADDR_CODING_CFG: begin
          s_d.coding_cfg = i_reg_wdata & `PXR_MASK_CODING_CFG;
        end
        `PXR_ADDR_PHY_CONTROL: begin
          s_d.phy_ctrl = i_reg_wdata & `PXR_MASK_PHY_CONTROL;
          if (i_reg_wdata[`PXR_BIT_BIST_START]) begin
            s_d.bist_run = 1'b1;
          end
        end
        `PXR_ADDR_TEN_MEG: begin
          s_d.ten_cfg = i_reg_wdata & `PXR_MASK_TEN_MEG;
        end
        `PXR_ADDR_CABLE_DIAG: begin
          s_d.cd_cfg = i_reg_wdata & `PXR_MASK_CABLE_DIAG;
        end
        default: begin
          // counters and reserved space swallow writes
          s_d.rd_valid = rd_ok;
        end
      endcase
    end

    // completion clears the start bit; a new start in the same cycle wins
    if (s_q.bist_run && i_bist_done && !(wr_ok && (i_reg_addr == `PXR_ADDR_PHY_CONTROL)
        && i_reg_wdata[`PXR_BIT_BIST_START])) begin
      s_d.bist_run = 1'b0;
    end

    // counters saturate; an event in the read cycle is counted afresh
    if (i_reg_rd && (i_reg_addr == `PXR_ADDR_FALSE_CARRIER)) begin
      s_d.fc_cnt = {{(`PXR_CNT_W-1){1'b0}}, i_false_carrier_evt};
    end else if (i_false_carrier_evt && (s_q.fc_cnt != CNT_MAX)) begin
      s_d.fc_cnt = s_q.fc_cnt + 1'b1;
    end
    if (i_reg_rd && (i_reg_addr == `PXR_ADDR_RX_ERROR)) begin
      s_d.rx_err_cnt = {{(`PXR_CNT_W-1){1'b0}}, i_rx_err_evt};
    end else if (i_rx_err_evt && (s_q.rx_err_cnt != CNT_MAX)) begin
      s_d.rx_err_cnt = s_q.rx_err_cnt + 1'b1;
    end

    // strap is caught once, on the first enabled cycle after reset
    if (!s_q.strap_done) begin
      s_d.phy_ctrl[4:0] = i_strap_phy_addr;
      s_d.strap_done    = 1'b1;
    end

    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `PXR_ADDR_NEXT_PAGE_TX:   s_d.rd_data = s_q.next_page_tx;
        `PXR_ADDR_STATUS_SUMMARY: s_d.rd_data = status_word;
        `PXR_ADDR_FALSE_CARRIER:  s_d.rd_data = {8'h00, s_q.fc_cnt};
        `PXR_ADDR_RX_ERROR:       s_d.rd_data = {8'h00, s_q.rx_err_cnt};
        `PXR_ADDR_CODING_CFG:     s_d.rd_data = s_q.coding_cfg;
        `PXR_ADDR_PHY_CONTROL:    s_d.rd_data = ctrl_word;
        `PXR_ADDR_TEN_MEG:        s_d.rd_data = ten_word;
        `PXR_ADDR_CABLE_DIAG:     s_d.rd_data = s_q.cd_cfg;
        default:                  s_d.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q              <= '0;
      s_q.next_page_tx <= P_NP_TX_RESET;
      s_q.coding_cfg   <= `PXR_RST_CODING_CFG;
      s_q.phy_ctrl     <= `PXR_RST_PHY_CONTROL;
      s_q.ten_cfg      <= `PXR_RST_TEN_MEG;
      s_q.cd_cfg       <= `PXR_RST_CABLE_DIAG;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_rd_data      = s_q.rd_data;
  assign o_rd_valid     = s_q.rd_valid & i_clk_en;
  assign o_next_page_tx = s_q.next_page_tx;
  assign o_coding_cfg   = s_q.coding_cfg;
  assign o_phy_ctrl     = s_q.phy_ctrl;
  assign o_phy_addr     = s_q.phy_ctrl[4:0];
  assign o_bist_start   = s_q.bist_run;
  assign o_ten_cfg      = s_q.ten_cfg;
  assign o_cd_cfg       = s_q.cd_cfg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence rd_at(logic [4:0] a);
    rd_ok && (i_reg_addr == a);
  endsequence

  sequence bist_kick;
    i_clk_en && wr_ok && (i_reg_addr == `PXR_ADDR_PHY_CONTROL)
      && i_reg_wdata[`PXR_BIT_BIST_START];
  endsequence

  sequence bist_finish;
    i_clk_en && s_q.bist_run && i_bist_done && !wr_ok;
  endsequence

  a_sc_live_read: assert property (rd_at(`PXR_ADDR_STATUS_SUMMARY) |=>
    o_rd_data[10] == $past(i_sig_detect))
    else $error("signal detect read does not follow the event");

  a_bist_self_clear: assert property (bist_finish |=> !o_bist_start)
    else $error("bist start did not clear after completion");

  a_bist_start_set: assert property (bist_kick |=> o_bist_start)
    else $error("bist start write not taken");

  a_cor_counter: assert property (rd_ok && (i_reg_addr == `PXR_ADDR_FALSE_CARRIER)
    && !i_false_carrier_evt |=>
    (o_rd_data[7:0] == $past(s_q.fc_cnt)) && (s_q.fc_cnt == 8'h00))
    else $error("false carrier count not cleared by read");

  a_cnt_write_ignored: assert property (i_clk_en && wr_ok && !i_reg_rd
    && (i_reg_addr == `PXR_ADDR_RX_ERROR) && !i_rx_err_evt |=> $stable(s_q.rx_err_cnt))
    else $error("receive error count changed by a write");

  a_perm_top_bits: assert property (rd_at(`PXR_ADDR_PHY_CONTROL) |=>
    o_rd_data[15:12] == `PXR_PERM_CTRL_TOP)
    else $error("permanent control bits changed");

  a_latch_low_hold: assert property (i_clk_en && !i_link_up ##1
    (i_clk_en && i_link_up && !rd_status)[*2] |=> !lat_val[`PXR_LAT_LINK])
    else $error("link latch released without a read");

  a_latch_high_hold: assert property (i_clk_en && i_rx_err_evt ##1
    (i_clk_en && !i_rx_err_evt && !rd_status)[*2] |=> lat_val[`PXR_LAT_RX_ERROR])
    else $error("receive error latch dropped without a read");

  a_rsvd_read_zero: assert property (rd_ok && (i_reg_addr inside {[5'h08:5'h0f],
    [5'h11:5'h13], 5'h17, 5'h18, [5'h1c:5'h1f]}) |=> o_rd_data == 16'h0000)
    else $error("reserved location read nonzero");
endmodule : pxr_ext_regs

// ---- pxr_host_model.sv ----
// management host model issuing one-cycle register strobes
`timescale 1ns/1ps
module pxr_host_model
  import pxr_pkg::*;
(
  input  wire logic        i_sys_clk,
  output logic      [4:0]  o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_wdata
);
  initial begin
    o_addr  = 5'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 16'h0000;
  end

  // released address and data lines flip so a stale value can never pass for a driven one
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    #1;
    o_wr    = w;
    o_rd    = ~w;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : xfer
endmodule : pxr_host_model

// ---- pxr_latch_bit.sv ----
// one status bit latched until a management read
`timescale 1ns/1ps
module pxr_latch_bit
  import pxr_pkg::*;
#(
  parameter pxr_latch_kind_t KIND = PXR_LATCH_HIGH
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_clk_en,
  input  wire logic i_cond,
  input  wire logic i_rd_clear,
  output logic      o_val
);
  pxr_latch_state_t s_q;
  pxr_latch_state_t s_d;

  // the event beats a read in the same cycle, so nothing is lost
  always_comb begin
    s_d = s_q;
    if (KIND == PXR_LATCH_HIGH) begin
      if (i_cond) begin
        s_d.val = 1'b1;
      end else if (i_rd_clear) begin
        s_d.val = 1'b0;
      end
    end else begin
      if (!i_cond) begin
        s_d.val = 1'b0;
      end else if (i_rd_clear) begin
        s_d.val = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_val = s_q.val;
endmodule : pxr_latch_bit

// ---- pxr_pkg.sv ----
// types shared by the extended register bank
package pxr_pkg;
  `include "pxr_regs.svh"

  typedef enum logic [0:0] {
    PXR_LATCH_LOW  = 1'b0,
    PXR_LATCH_HIGH = 1'b1
  } pxr_latch_kind_t;

  typedef struct packed {
    logic [`PXR_DATA_W-1:0] next_page_tx;
    logic [`PXR_DATA_W-1:0] coding_cfg;
    logic [`PXR_DATA_W-1:0] phy_ctrl;
    logic [`PXR_DATA_W-1:0] ten_cfg;
    logic [`PXR_DATA_W-1:0] cd_cfg;
    logic                   bist_run;
    logic [`PXR_CNT_W-1:0]  fc_cnt;
    logic [`PXR_CNT_W-1:0]  rx_err_cnt;
    logic                   strap_done;
    logic [`PXR_DATA_W-1:0] rd_data;
    logic                   rd_valid;
  } pxr_state_t;

  typedef struct packed {
    logic val;
  } pxr_latch_state_t;
endpackage : pxr_pkg

// ---- pxr_regs.svh ----
// register offsets, field positions, masks and reset values of the extended bank
`ifndef PXR_REGS_SVH
`define PXR_REGS_SVH

`define PXR_ADDR_W                5
`define PXR_DATA_W                16
`define PXR_CNT_W                 8

`define PXR_ADDR_NEXT_PAGE_TX     5'h07
`define PXR_ADDR_STATUS_SUMMARY   5'h10
`define PXR_ADDR_FALSE_CARRIER    5'h14
`define PXR_ADDR_RX_ERROR         5'h15
`define PXR_ADDR_CODING_CFG       5'h16
`define PXR_ADDR_PHY_CONTROL      5'h19
`define PXR_ADDR_TEN_MEG          5'h1a
`define PXR_ADDR_CABLE_DIAG       5'h1b

`define PXR_MASK_NEXT_PAGE_TX     16'hbfff
`define PXR_MASK_CODING_CFG       16'h1f27
`define PXR_MASK_PHY_CONTROL      16'h097f
`define PXR_MASK_TEN_MEG          16'h01c3
`define PXR_MASK_CABLE_DIAG       16'hff1f

`define PXR_RST_CODING_CFG        16'h0000
`define PXR_RST_PHY_CONTROL       16'h0000
`define PXR_RST_TEN_MEG           16'h0000
`define PXR_RST_CABLE_DIAG        16'h0000

`define PXR_BIT_BIST_START        9
`define PXR_PERM_CTRL_TOP         4'h0

`define PXR_LAT_LINK              0
`define PXR_LAT_JABBER            1
`define PXR_LAT_PAGE_RX           2
`define PXR_LAT_FALSE_CARRIER     3
`define PXR_LAT_RX_ERROR          4
`define PXR_LAT_N                 5
`define PXR_LAT_HIGH_VEC          5'h1e

`endif

// ---- tb_top.sv ----
// self-checking bench of the extended register bank
`timescale 1ns/1ps
module tb_top
  import pxr_pkg::*;
;
  logic        i_sys_clk;
  logic        i_rst;
  logic [4:0]  addr;
  logic        wr;
  logic        rd;
  logic        en;
  logic [15:0] wdata;
  logic [15:0] o_rd_data;
  logic        o_rd_valid;
  logic [4:0]  ev;
  logic [10:0] lv;
  logic        bdone;
  logic [4:0]  strap;
  logic [15:0] ocfg [5];
  logic [4:0]  o_phy_addr;
  logic        o_bist_start;
  logic [15:0] exp_q [$];
  logic [15:0] msk_q [$];
  int          error_cnt;
  int          num_checks;
  logic [4:0]  ra [5] = '{5'h07, 5'h16, 5'h19, 5'h1a, 5'h1b};
  logic [15:0] rm [5] = '{16'hbfff, 16'h1f27, 16'h097f, 16'h01c3, 16'hff1f};

  initial i_sys_clk = 1'b0;
  always #4 i_sys_clk = ~i_sys_clk;

  pxr_host_model i_pxr_host_model (.i_sys_clk(i_sys_clk), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));

  pxr_ext_regs i_pxr_ext_regs (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(en),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_link_up(~ev[4]),
    .i_jabber(ev[2]), .i_page_rx(ev[3]), .i_false_carrier_evt(ev[0]),
    .i_rx_err_evt(ev[1]), .i_polarity(lv[7]), .i_sig_detect(lv[6]),
    .i_descr_lock(lv[5]), .i_remote_fault(lv[4]), .i_an_done(lv[3]),
    .i_loopback(lv[2]), .i_duplex(lv[1]), .i_speed10(lv[0]), .i_pause_sts(lv[8]),
    .i_bist_done(bdone), .i_bist_pass(lv[9]), .i_polarity_10(lv[10]),
    .i_strap_phy_addr(strap), .o_next_page_tx(ocfg[0]), .o_coding_cfg(ocfg[1]),
    .o_phy_ctrl(ocfg[2]), .o_phy_addr(o_phy_addr), .o_bist_start(o_bist_start),
    .o_ten_cfg(ocfg[3]), .o_cd_cfg(ocfg[4]));

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic finish_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic rdx(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    i_pxr_host_model.xfer(1'b0, a, 16'h0000);
  endtask : rdx

  task automatic pulse(input logic [4:0] m);
    @(posedge i_sys_clk);
    #1;
    ev = m;
    @(posedge i_sys_clk);
    #1;
    ev = 5'h00;
  endtask : pulse

  // a read answer is matched against the oldest noted expectation
  always @(posedge i_sys_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("rd_extra", 16'h0000, 16'hffff);
      end else begin
        check("rd_data", exp_q[0] & msk_q[0], o_rd_data & msk_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] e;
    int          n;
    void'($urandom(13));
    i_rst = 1'b1;
    ev    = 5'h00;
    bdone = 1'b0;
    en    = 1'b1;
    lv    = 11'($urandom);
    strap = 5'($urandom);
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    rdx(5'h10, {3'b000, lv[7], 1'b0, lv[6:5], 2'b00, lv[4], 1'b0, lv[3:0], 1'b0},
      16'hffff);
    for (int a = 8; a < 32; a++) begin
      if (!(a inside {16, 20, 21, 22, 25, 26, 27})) begin
        i_pxr_host_model.xfer(1'b1, a[4:0], 16'($urandom));
        rdx(a[4:0], 16'h0000, 16'hffff);
      end
    end
    for (int i = 0; i < 5; i++) begin
      d    = 16'($urandom) | 16'hf000;
      d[9] = 1'b0;
      i_pxr_host_model.xfer(1'b1, ra[i], d);
      e = d & rm[i];
      check("cfg_out", e, ocfg[i]);
      if (i == 2) check("phy_addr", {11'h000, d[4:0]}, {11'h000, o_phy_addr});
      if (i == 2) e = e | {5'h00, lv[9], 2'b00, lv[8], 7'h00};
      if (i == 3) e = e | {11'h000, lv[10], 4'h0};
      rdx(ra[i], e, 16'hffff);
    end
    // let the pending answer be seen before freezing, or it would be masked
    @(posedge i_sys_clk);
    #1;
    en = 1'b0;
    i_pxr_host_model.xfer(1'b1, 5'h1b, 16'h0000);
    i_pxr_host_model.xfer(1'b0, 5'h1b, 16'h0000);
    en = 1'b1;
    check("cd_frozen", d & rm[4], ocfg[4]);
    i_pxr_host_model.xfer(1'b1, 5'h19, 16'h0200);
    check("bist_on", 16'h0001, {15'h0000, o_bist_start});
    rdx(5'h19, 16'h0200, 16'h0200);
    @(posedge i_sys_clk);
    #1;
    bdone = 1'b1;
    @(posedge i_sys_clk);
    #1;
    bdone = 1'b0;
    check("bist_off", 16'h0000, {15'h0000, o_bist_start});
    rdx(5'h19, 16'h0000, 16'h0200);
    for (int k = 0; k < 2; k++) begin
      n = 1 + $urandom % 5;
      repeat (n) pulse(5'h01 << k);
      i_pxr_host_model.xfer(1'b1, 5'h14 + k[4:0], 16'hffff);
      rdx(5'h14 + k[4:0], n[15:0], 16'hffff);
      rdx(5'h14 + k[4:0], 16'h0000, 16'hffff);
    end
    lv[6] = 1'b1;
    pulse(5'h1c);
    repeat (3) @(posedge i_sys_clk);
    rdx(5'h10, {2'b00, 1'b1, lv[7], 1'b1, lv[6:5], 1'b1, 1'b0, lv[4], 1'b1, lv[3:0], 1'b0},
      16'hffff);
    lv[6] = 1'b0;
    rdx(5'h10, {3'b000, lv[7], 1'b0, lv[6:5], 2'b00, lv[4], 1'b0, lv[3:0], 1'b1},
      16'hffff);
    for (int w = 0; w < 10 && exp_q.size() != 0; w++) @(posedge i_sys_clk);
    if (exp_q.size() != 0) check("rd_missing", 16'h0000, 16'hffff);
    finish_test();
  end
endmodule : tb_top
